// ===== csor_pkg.sv
package csor_pkg;
	localparam logic [7:0] CSOR_STATUS_ADDR = 8'h03;
	localparam int CSOR_BIT_WAKE = 7;
	localparam int CSOR_BIT_PAGE = 5;
	localparam int CSOR_BIT_EXP = 4;
	localparam int CSOR_BIT_PD = 3;
	localparam int CSOR_BIT_Z = 2;
	localparam int CSOR_BIT_DC = 1;
	localparam int CSOR_BIT_C = 0;
	localparam int CSOR_OPT_WAKE_N = 7;
	localparam int CSOR_OPT_PULL_N = 6;
	localparam int CSOR_OPT_SRC = 5;
	localparam int CSOR_OPT_EDGE = 4;
	localparam int CSOR_OPT_OWNER = 3;
	localparam logic [7:0] CSOR_OPT_RESET = 8'hFF;
	localparam logic [7:0] CSOR_STATUS_WR_MASK = 8'hA7;
	localparam logic [7:0] CSOR_ARITH_MASK = 8'h07;
	localparam logic [7:0] CSOR_ZERO_KEEP = 8'h1B;
	localparam logic [9:0] CSOR_PAGE1_BASE = 10'h200;
	localparam logic [9:0] CSOR_PAGE0_BASE = 10'h000;
	typedef enum logic [2:0]
	{
		CSOR_OP_NONE = 3'h0,
		CSOR_OP_ADD = 3'h1,
		CSOR_OP_SUB = 3'h2,
		CSOR_OP_RR = 3'h3,
		CSOR_OP_RL = 3'h4,
		CSOR_OP_LOGIC = 3'h5,
		CSOR_OP_CLEAR = 3'h6
	} csor_op_t;
endpackage

// ===== csor_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface csor_flag_if;
	logic [7:0] a;
	logic [7:0] b;
	csor_pkg::csor_op_t op;
	logic cin;
	logic [7:0] result;
	logic z;
	logic dc;
	logic c;
	logic z_upd;
	logic dc_upd;
	logic c_upd;
	modport core (output a, b, op, cin, input result, z, dc, c, z_upd,
		dc_upd, c_upd);
	modport alu (input a, b, op, cin, output result, z, dc, c, z_upd,
		dc_upd, c_upd);
endinterface
`default_nettype wire

// ===== csor_flag_alu.sv
`timescale 1ns/1ps
`default_nettype none
module csor_flag_alu
(
	csor_flag_if.alu fl
);
	import csor_pkg::*;
	logic [8:0] sum;
	logic [4:0] nib;
	always_comb
	begin
		sum = 9'h000;
		nib = 5'h00;
		fl.result = 8'h00;
		fl.z = 1'b0;
		fl.dc = 1'b0;
		fl.c = 1'b0;
		fl.z_upd = 1'b0;
		fl.dc_upd = 1'b0;
		fl.c_upd = 1'b0;
		unique case (fl.op)
			CSOR_OP_ADD:
			begin
				sum = {1'b0, fl.a} + {1'b0, fl.b};
				nib = {1'b0, fl.a[3:0]} + {1'b0, fl.b[3:0]};
				fl.result = sum[7:0];
				fl.c = sum[8];
				fl.dc = nib[4];
				{fl.z_upd, fl.dc_upd, fl.c_upd} = 3'h7;
			end
			CSOR_OP_SUB:
			begin
				// file minus w; C and DC are inverted borrows
				sum = {1'b0, fl.a} + {1'b0, ~fl.b} + 9'h001;
				nib = {1'b0, fl.a[3:0]} + {1'b0, ~fl.b[3:0]} + 5'h01;
				fl.result = sum[7:0];
				fl.c = sum[8];
				fl.dc = nib[4];
				{fl.z_upd, fl.dc_upd, fl.c_upd} = 3'h7;
			end
			CSOR_OP_RR:
			begin
				fl.result = {fl.cin, fl.a[7:1]};
				fl.c = fl.a[0];
				fl.c_upd = 1'b1;
			end
			CSOR_OP_RL:
			begin
				fl.result = {fl.a[6:0], fl.cin};
				fl.c = fl.a[7];
				fl.c_upd = 1'b1;
			end
			CSOR_OP_LOGIC:
			begin
				fl.result = fl.a;
				fl.z_upd = 1'b1;
			end
			CSOR_OP_CLEAR:
			begin
				fl.result = 8'h00;
				fl.z_upd = 1'b1;
			end
			CSOR_OP_NONE:
			begin
				fl.result = fl.a;
			end
			default:
			begin
				fl.result = 8'h00;
			end
		endcase
		fl.z = (fl.result == 8'h00);
	end
endmodule
`default_nettype wire

// ===== csor_regs.sv
`timescale 1ns/1ps
`default_nettype none
module csor_regs
#(
	parameter int PIN_COUNT = 6
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_up_reset,
	input wire logic wake_reset,
	input wire logic exec_valid,
	input wire csor_pkg::csor_op_t exec_op,
	input wire logic [7:0] exec_addr,
	input wire logic [7:0] exec_file,
	input wire logic [7:0] exec_w,
	input wire logic exec_to_file,
	input wire logic option_load,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic watchdog_timeout,
	input wire logic [PIN_COUNT-1:0] pin_direction_bit,
	input wire logic [PIN_COUNT-1:0] pin_wake_capable,
	output logic [7:0] core_status_flags,
	output logic [7:0] exec_result,
	output logic [9:0] page_base,
	output logic timer_source_select,
	output logic timer_edge_select,
	output logic prescaler_owner,
	output logic [2:0] prescale_ratio_field,
	output logic [3:0] timer_ratio_log2,
	output logic [3:0] watchdog_ratio_log2,
	output logic [PIN_COUNT-1:0] pin_wake_enable,
	output logic [PIN_COUNT-1:0] pin_pullup_enable,
	output logic timer_pin_is_input
);
	import csor_pkg::*;
	if (PIN_COUNT < 1 || PIN_COUNT > 8)
	begin : g_bad_pin_count
		$error("PIN_COUNT out of range");
	end

	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] option_r;
	logic [7:0] option_nxt;
	logic wr_status;
	logic [7:0] alu_res;

	csor_flag_if fl();
	assign fl.a = exec_file;
	assign fl.b = exec_w;
	assign fl.op = exec_op;
	assign fl.cin = status_r[CSOR_BIT_C];
	csor_flag_alu u_alu
	(
		.fl(fl)
	);
	assign alu_res = fl.result;

	assign wr_status = exec_valid && exec_to_file
		&& exec_addr == CSOR_STATUS_ADDR;

	always_comb
	begin
		status_nxt = status_r;
		if (wr_status)
		begin
			// flag bits written from the result unless the op owns them; a clear keeps DC and C
			status_nxt = (status_r & ~CSOR_STATUS_WR_MASK)
				| (alu_res & CSOR_STATUS_WR_MASK);
			if (exec_op == CSOR_OP_CLEAR)
				status_nxt = status_r & CSOR_ZERO_KEEP;
		end
		if (exec_valid)
		begin
			if (fl.z_upd)
				status_nxt[CSOR_BIT_Z] = fl.z;
			if (fl.dc_upd)
				status_nxt[CSOR_BIT_DC] = fl.dc;
			if (fl.c_upd)
				status_nxt[CSOR_BIT_C] = fl.c;
		end
		if (watchdog_clear_instr)
		begin
			status_nxt[CSOR_BIT_EXP] = 1'b1;
			status_nxt[CSOR_BIT_PD] = 1'b1;
		end
		else if (sleep_instr)
		begin
			status_nxt[CSOR_BIT_EXP] = 1'b1;
			status_nxt[CSOR_BIT_PD] = 1'b0;
		end
		if (watchdog_timeout)
			status_nxt[CSOR_BIT_EXP] = 1'b0;
		if (power_up_reset)
		begin
			status_nxt[7:3] = 5'h03;
		end
		else if (wake_reset)
		begin
			status_nxt[CSOR_BIT_WAKE] = 1'b1;
			status_nxt[CSOR_BIT_PAGE] = 1'b0;
		end
	end

	always_comb
	begin
		option_nxt = option_r;
		if (power_up_reset || wake_reset)
			option_nxt = CSOR_OPT_RESET;
		else if (option_load)
			option_nxt = exec_w;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_r <= 8'h18;
			option_r <= CSOR_OPT_RESET;
		end
		else
		begin
			status_r <= status_nxt;
			option_r <= option_nxt;
		end
	end

	assign core_status_flags = status_r;
	assign exec_result = alu_res;
	assign page_base = status_r[CSOR_BIT_PAGE] ? CSOR_PAGE1_BASE
		: CSOR_PAGE0_BASE;
	assign timer_source_select = option_r[CSOR_OPT_SRC];
	assign timer_pin_is_input = option_r[CSOR_OPT_SRC];
	assign timer_edge_select = option_r[CSOR_OPT_EDGE];
	assign prescaler_owner = option_r[CSOR_OPT_OWNER];
	assign prescale_ratio_field = option_r[2:0];
	assign timer_ratio_log2 = {1'b0, option_r[2:0]} + 4'h1;
	assign watchdog_ratio_log2 = {1'b0, option_r[2:0]};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++)
		begin : g_pin
			assign pin_wake_enable[gi] = pin_wake_capable[gi]
				&& pin_direction_bit[gi]
				&& !option_r[CSOR_OPT_WAKE_N];
			assign pin_pullup_enable[gi] = pin_wake_capable[gi]
				&& pin_direction_bit[gi]
				&& !option_r[CSOR_OPT_PULL_N];
		end
	endgenerate

	// a move writes the file operand; expiry and power-down stay put
	a_status_write_masked: assert property (@(posedge clk)
		disable iff (!resetn)
		wr_status && exec_op == CSOR_OP_NONE && !power_up_reset
		&& !wake_reset && !watchdog_clear_instr && !sleep_instr
		&& !watchdog_timeout
		|=> status_r[4:3] == $past(status_r[4:3])
		&& status_r[7] == $past(exec_file[7]))
		else $error("status write reached protected bits");

	a_clear_pattern: assert property (@(posedge clk)
		disable iff (!resetn)
		wr_status && exec_op == CSOR_OP_CLEAR && !power_up_reset
		&& !wake_reset && !watchdog_clear_instr && !sleep_instr
		&& !watchdog_timeout
		|=> status_r == (($past(status_r) & 8'h1B) | 8'h04))
		else $error("clear of status gave wrong pattern");

	a_add_flags_win: assert property (@(posedge clk)
		disable iff (!resetn)
		wr_status && exec_op == CSOR_OP_ADD && !power_up_reset
		|=> status_r[0]
		== $past(({1'b0, exec_file} + {1'b0, exec_w}) > 9'h0FF))
		else $error("add carry not from result");

	a_nibble_sub: assert property (@(posedge clk)
		disable iff (!resetn)
		exec_valid && exec_op == CSOR_OP_SUB
		|=> status_r[1] == ($past(exec_file[3:0]) >= $past(exec_w[3:0])))
		else $error("subtract nibble flag wrong");

	a_sleep_flags: assert property (@(posedge clk)
		disable iff (!resetn)
		sleep_instr && !watchdog_clear_instr && !watchdog_timeout
		&& !power_up_reset
		|=> status_r[4:3] == 2'b10)
		else $error("sleep did not set expiry, clear power-down");

	a_timeout_clears: assert property (@(posedge clk)
		disable iff (!resetn)
		watchdog_timeout && !power_up_reset |=> !status_r[4])
		else $error("timeout did not clear expiry");

	a_wake_reset_flag: assert property (@(posedge clk)
		disable iff (!resetn)
		wake_reset && !power_up_reset
		|=> status_r[7] && option_r == 8'hFF)
		else $error("wake reset flag or option default wrong");

	sequence s_option_taken;
		option_r == $past(exec_w);
	endsequence

	// after the load the value holds unless a new load or reset came
	sequence s_option_kept;
		$past(option_load || power_up_reset || wake_reset)
		|| option_r == $past(option_r);
	endsequence

	a_option_load: assert property (@(posedge clk)
		disable iff (!resetn)
		option_load && !power_up_reset && !wake_reset
		|=> s_option_taken ##1 s_option_kept)
		else $error("option not loaded from w");

	a_output_no_pull: assert property (@(posedge clk)
		disable iff (!resetn)
		(pin_pullup_enable & ~pin_direction_bit) == '0
		&& (pin_wake_enable & ~pin_direction_bit) == '0)
		else $error("output pin kept pull-up or wake");

	a_ratio_offset: assert property (@(posedge clk)
		disable iff (!resetn)
		timer_ratio_log2 == watchdog_ratio_log2 + 4'h1)
		else $error("timer ratio not twice watchdog ratio");
endmodule
`default_nettype wire

// ===== csor_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module csor_core_model
import csor_pkg::*;
(
	input wire logic clk,
	output logic exec_valid,
	output csor_op_t exec_op,
	output logic [7:0] exec_addr,
	output logic [7:0] exec_file,
	output logic [7:0] exec_w,
	output logic exec_to_file,
	output logic [2:0] evs
);
	initial
	begin
		exec_valid = 1'b0;
		exec_op = CSOR_OP_NONE;
		exec_addr = CSOR_STATUS_ADDR;
		exec_file = 8'h00;
		exec_w = 8'h00;
		exec_to_file = 1'b0;
		evs = 3'h0;
	end
	// status takes each op's flags, and its result when dst is set at the status address; operands stay for the result
	task automatic run(input csor_op_t op, input logic [7:0] f,
		input logic [7:0] w, input logic dst);
		@(negedge clk);
		exec_valid = 1'b1;
		exec_op = op;
		exec_file = f;
		exec_w = w;
		exec_to_file = dst;
		@(negedge clk);
		exec_valid = 1'b0;
	endtask
	// points later instructions at another file address
	task automatic aim(input logic [7:0] a);
		exec_addr = a;
	endtask
	// pulses the event lines (option load, watchdog clear, sleep) for one cycle with w on the bus
	task automatic strobe(input logic [2:0] e, input logic [7:0] w);
		@(negedge clk);
		evs = e;
		exec_w = w;
		@(negedge clk);
		evs = 3'h0;
	endtask
endmodule
`default_nettype wire

// ===== tb_csor_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_csor_regs;
import csor_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic power_up_reset = 1'b0;
	logic wake_reset = 1'b0;
	logic watchdog_timeout = 1'b0;
	logic [5:0] pin_direction_bit = 6'h2B;
	logic [5:0] cap = 6'h1B;
	logic exec_valid, exec_to_file;
	csor_op_t exec_op;
	logic [7:0] exec_addr, exec_file, exec_w, core_status_flags, exec_result;
	logic [2:0] evs, prescale_ratio_field;
	logic [9:0] page_base;
	logic timer_source_select, timer_edge_select, prescaler_owner;
	logic timer_pin_is_input;
	logic [3:0] timer_ratio_log2, watchdog_ratio_log2;
	logic [5:0] pin_wake_enable, pin_pullup_enable;
	int n_errors = 0;
	int cmp_count = 0;
	always #10 clk = ~clk;
	csor_core_model i_core (.clk(clk), .exec_valid(exec_valid),
		.exec_op(exec_op), .exec_addr(exec_addr), .exec_file(exec_file),
		.exec_w(exec_w), .exec_to_file(exec_to_file), .evs(evs));
	csor_regs #(.PIN_COUNT(6)) i_dut (.clk(clk), .resetn(resetn),
		.power_up_reset(power_up_reset), .wake_reset(wake_reset),
		.exec_valid(exec_valid), .exec_op(exec_op), .exec_addr(exec_addr),
		.exec_file(exec_file), .exec_w(exec_w), .exec_to_file(exec_to_file),
		.option_load(evs[0]), .watchdog_clear_instr(evs[1]),
		.sleep_instr(evs[2]), .watchdog_timeout(watchdog_timeout),
		.pin_direction_bit(pin_direction_bit), .pin_wake_capable(cap),
		.core_status_flags(core_status_flags), .exec_result(exec_result),
		.page_base(page_base), .timer_source_select(timer_source_select),
		.timer_edge_select(timer_edge_select),
		.prescaler_owner(prescaler_owner),
		.prescale_ratio_field(prescale_ratio_field),
		.timer_ratio_log2(timer_ratio_log2),
		.watchdog_ratio_log2(watchdog_ratio_log2),
		.pin_wake_enable(pin_wake_enable),
		.pin_pullup_enable(pin_pullup_enable),
		.timer_pin_is_input(timer_pin_is_input));
	task automatic chk(input string nm, input logic [9:0] e,
		input logic [9:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task automatic op(input csor_op_t o, input logic [7:0] f,
		input logic [7:0] w, input logic dst, input logic [7:0] e);
		i_core.run(o, f, w, dst);
		chk("status", {2'h0, e}, {2'h0, core_status_flags});
	endtask
	task automatic hw(input logic [2:0] e);
		@(negedge clk);
		{wake_reset, power_up_reset, watchdog_timeout} = e;
		@(negedge clk);
		{wake_reset, power_up_reset, watchdog_timeout} = 3'h0;
	endtask
	task automatic optchk(input logic [7:0] w);
		chk("src", {9'h0, w[5]}, {9'h0, timer_source_select});
		chk("tpin", {9'h0, w[5]}, {9'h0, timer_pin_is_input});
		chk("edge", {9'h0, w[4]}, {9'h0, timer_edge_select});
		chk("owner", {9'h0, w[3]}, {9'h0, prescaler_owner});
		chk("ratio", {7'h0, w[2:0]}, {7'h0, prescale_ratio_field});
		chk("tlog", {7'h0, w[2:0]} + 10'h1, {6'h0, timer_ratio_log2});
		chk("wlog", {7'h0, w[2:0]}, {6'h0, watchdog_ratio_log2});
		chk("wake", {4'h0, pin_direction_bit & cap & {6{~w[7]}}},
			{4'h0, pin_wake_enable});
		chk("pull", {4'h0, pin_direction_bit & cap & {6{~w[6]}}},
			{4'h0, pin_pullup_enable});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#1000000;
		n_errors++;
		close_out;
	end
	initial
	begin
		logic [7:0] w;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		chk("status", 10'h018, {2'h0, core_status_flags});
		chk("tpin", 10'h001, {9'h0, timer_pin_is_input});
		optchk(8'hFF);
		$display("test reset done");
		op(CSOR_OP_NONE, 8'hFF, 8'hFF, 1'b1, 8'hBF);
		chk("page", 10'h200, page_base);
		op(CSOR_OP_NONE, 8'hA0, 8'hA0, 1'b1, 8'hB8);
		op(CSOR_OP_CLEAR, 8'hA0, 8'h00, 1'b1, 8'h1C);
		chk("page", 10'h000, page_base);
		op(CSOR_OP_ADD, 8'h0F, 8'h01, 1'b1, 8'h1A);
		chk("result", 10'h010, {2'h0, exec_result});
		op(CSOR_OP_ADD, 8'hFF, 8'h01, 1'b0, 8'h1F);
		op(CSOR_OP_SUB, 8'h10, 8'h01, 1'b0, 8'h19);
		op(CSOR_OP_SUB, 8'h01, 8'h02, 1'b0, 8'h18);
		chk("result", 10'h0FF, {2'h0, exec_result});
		op(CSOR_OP_RR, 8'h01, 8'h00, 1'b0, 8'h19);
		op(CSOR_OP_RL, 8'h01, 8'h00, 1'b0, 8'h18);
		op(CSOR_OP_RL, 8'h80, 8'h00, 1'b0, 8'h19);
		op(CSOR_OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h1D);
		i_core.aim(8'h07);
		op(CSOR_OP_NONE, 8'hFF, 8'hFF, 1'b1, 8'h1D);
		i_core.aim(CSOR_STATUS_ADDR);
		$display("test arith done");
		i_core.strobe(3'h4, 8'h00);
		chk("status", 10'h015, {2'h0, core_status_flags});
		hw(3'h1);
		chk("status", 10'h005, {2'h0, core_status_flags});
		op(CSOR_OP_NONE, 8'hFF, 8'hFF, 1'b1, 8'hA7);
		i_core.strobe(3'h2, 8'h00);
		chk("status", 10'h0BF, {2'h0, core_status_flags});
		$display("test events done");
		for (int i = 0; i < 8; i++)
		begin
			w = i[0] ? {5'h15, i[2:0]} : {5'h0A, i[2:0]};
			pin_direction_bit = 6'h2B ^ {6{i[0]}};
			i_core.strobe(3'h1, w);
			optchk(w);
		end
		chk("status", 10'h0BF, {2'h0, core_status_flags});
		hw(3'h4);
		chk("status", 10'h09F, {2'h0, core_status_flags});
		optchk(8'hFF);
		hw(3'h2);
		chk("status", 10'h01F, {2'h0, core_status_flags});
		$display("test option done");
		i_core.strobe(3'h1, 8'h00);
		@(negedge clk);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		chk("status", 10'h018, {2'h0, core_status_flags});
		optchk(8'hFF);
		$display("test rerun done");
		close_out;
	end
endmodule
`default_nettype wire
